// file: hdl/rfc_pkg.sv
// Constants and state type for the radio interface control block
package rfc_pkg;
  localparam int          CLK_NS        = 50;
  localparam int          SER_HALF_NS   = 200;
  localparam int          SER_HALF_CYC  = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RAMP_TICK_NS  = 1000;
  localparam int          RAMP_TICK_CYC = (RAMP_TICK_NS / CLK_NS < 1) ? 1 : RAMP_TICK_NS / CLK_NS;
  localparam int          SER_W         = 24;
  localparam int          SER_LW        = 5;
  localparam int          PAR_W         = 10;
  localparam int          NBANK         = 5;
  localparam int          BANK_W        = 3;
  localparam int          NENT          = 16;
  localparam int          ENT_W         = 8;
  localparam int          SCL_W         = 10;
  localparam int          DAC_W         = 10;
  localparam int          NSLOT         = 7;
  localparam int          FT_W          = 13;
  localparam int          SCL_SHIFT     = 8;
  localparam int          HALF_ENT      = 8;
  localparam int          NSAMP         = 32;
  localparam int          BIT_HIGH_BAND_TX_SWITCH     = 0;
  localparam int          BIT_LOW_BAND_TX_SWITCH     = 1;
  localparam int          BIT_UB_RX     = 2;
  localparam int          BIT_AMP_EN    = 4;
  localparam int          BIT_AMP_BAND  = 5;
  localparam int          BIT_MOD_SUP   = 8;
  localparam int          BIT_OSC_EN    = 9;
  localparam logic [7:0]  DIV_RST       = 8'h00;

  typedef struct packed {
    logic [SER_W-1:0]                        ser_wbuf;
    logic [SER_LW-1:0]                       ser_wlen;
    logic                                    ser_wsel;
    logic                                    ser_pend;
    logic [SER_W-1:0]                        ser_sh;
    logic [SER_LW-1:0]                       ser_cnt;
    logic [7:0]                              ser_div;
    logic                                    ser_act;
    logic                                    ser_clk;
    logic                                    ser_dat;
    logic                                    sel_a;
    logic                                    sel_b;
    logic [PAR_W-1:0]                        par_wbuf;
    logic [PAR_W-1:0]                        par_bus;
    logic [NBANK-1:0][NENT-1:0][ENT_W-1:0]   prof;
    logic [NBANK-1:0][SCL_W-1:0]             scl_l;
    logic [NBANK-1:0][SCL_W-1:0]             scl_r;
    logic [NSLOT-1:0][BANK_W-1:0]            slot_bank;
    logic [NSLOT-1:0]                        slot_en;
    logic [2:0]                              slot_cnt;
    logic                                    rmp_act;
    logic [4:0]                              rmp_k;
    logic [BANK_W-1:0]                       rmp_bank;
    logic [7:0]                              rmp_div;
    logic [DAC_W-1:0]                        rmp_dac;
    logic [FT_W-1:0]                         ft_code;
  } rfc_state_type;
endpackage : rfc_pkg

// file: hdl/rfc_radio_ctrl.sv
// Radio interface control: serial port, timed bus, power ramp and frequency trim
`timescale 1ns/1ps
module rfc_radio_ctrl (
  input  wire logic                            ref_clk,
  input  wire logic                            resetn,
  input  wire logic                            clk_en,
  input  wire logic                            frame_event_valid,
  input  wire logic                            frame_start,
  input  wire logic                            ramp_event,
  input  wire logic                            ser_wr,
  input  wire logic [rfc_pkg::SER_W-1:0]       ser_wr_data,
  input  wire logic [rfc_pkg::SER_LW-1:0]      ser_wr_len,
  input  wire logic                            ser_wr_sel,
  input  wire logic                            par_wr,
  input  wire logic [rfc_pkg::PAR_W-1:0]       par_wr_data,
  input  wire logic                            prof_wr,
  input  wire logic [rfc_pkg::BANK_W-1:0]      prof_bank,
  input  wire logic [3:0]                      prof_idx,
  input  wire logic [rfc_pkg::ENT_W-1:0]       prof_val,
  input  wire logic                            scl_wr,
  input  wire logic [rfc_pkg::SCL_W-1:0]       scl_left,
  input  wire logic [rfc_pkg::SCL_W-1:0]       scl_right,
  input  wire logic                            slot_wr,
  input  wire logic [2:0]                      slot_idx,
  input  wire logic [rfc_pkg::BANK_W-1:0]      slot_bank_sel,
  input  wire logic                            slot_enable,
  input  wire logic                            ft_wr,
  input  wire logic [rfc_pkg::FT_W-1:0]        ft_wr_code,
  output logic                                 serial_radio_clock,
  output logic                                 serial_radio_data,
  output logic                                 serial_radio_select_a,
  output logic                                 serial_radio_select_b,
  output logic                                 ser_busy,
  output logic                                 ser_pending,
  output logic [rfc_pkg::PAR_W-1:0]            timed_output_bus,
  output logic                                 high_band_tx_switch,
  output logic                                 low_band_tx_switch,
  output logic                                 upper_band_rx_switch,
  output logic                                 amplifier_enable,
  output logic                                 amplifier_band_select,
  output logic                                 radio_module_supply_enable,
  output logic                                 rf_oscillator_enable,
  output logic [rfc_pkg::DAC_W-1:0]            ramp_dac_code,
  output logic                                 ramp_busy,
  output logic [2:0]                           ramp_slot_count,
  output logic [rfc_pkg::FT_W-1:0]             freq_trim_code
);

  rfc_pkg::rfc_state_type st_ff;
  rfc_pkg::rfc_state_type nxt_st;

  // Truncate entry times factor to the ten-bit intermediate
  function automatic logic [rfc_pkg::DAC_W-1:0] scale_ent(
    input logic [rfc_pkg::ENT_W-1:0] ent,
    input logic [rfc_pkg::SCL_W-1:0] fac
  );
    logic [rfc_pkg::ENT_W+rfc_pkg::SCL_W-1:0] prod;
    prod = ent * fac;
    return prod[rfc_pkg::SCL_SHIFT +: rfc_pkg::DAC_W];
  endfunction : scale_ent

  // Intermediate value i of a bank with the half-dependent factor
  function automatic logic [rfc_pkg::DAC_W-1:0] inter_val(
    input rfc_pkg::rfc_state_type s,
    input logic [rfc_pkg::BANK_W-1:0] b,
    input logic [3:0] i
  );
    logic [rfc_pkg::SCL_W-1:0] fac;
    fac = (i < 4'(rfc_pkg::HALF_ENT)) ? s.scl_l[b] : s.scl_r[b];
    return scale_ent(s.prof[b][i], fac);
  endfunction : inter_val

  logic [rfc_pkg::DAC_W-1:0] smp_cur;
  logic [rfc_pkg::DAC_W-1:0] smp_nxt;
  logic [rfc_pkg::DAC_W:0]   smp_sum;
  logic [rfc_pkg::DAC_W-1:0] smp_out;
  logic [rfc_pkg::SER_W-1:0] ser_load;

  always_comb begin
    // Left-align the word so the first bit to send sits at the top
    ser_load = st_ff.ser_wbuf << (rfc_pkg::SER_W - int'(st_ff.ser_wlen));
    smp_cur = inter_val(st_ff, st_ff.rmp_bank, st_ff.rmp_k[4:1]);
    smp_nxt = (st_ff.rmp_k[4:1] == 4'hf) ? smp_cur
            : inter_val(st_ff, st_ff.rmp_bank, st_ff.rmp_k[4:1] + 4'h1);
    smp_sum = {1'b0, smp_cur} + {1'b0, smp_nxt};
    // Odd samples take the midpoint; the last one holds the final value
    smp_out = st_ff.rmp_k[0] ? smp_sum[rfc_pkg::DAC_W:1] : smp_cur;
  end

  always_comb begin
    nxt_st = st_ff;

    // Serial port: event retires the pending word first, a same-cycle write re-arms it
    if (frame_event_valid && st_ff.ser_pend && !st_ff.ser_act) begin
      nxt_st.ser_pend = 1'b0;
      nxt_st.ser_act  = 1'b1;
      nxt_st.ser_sh   = ser_load << 1;
      nxt_st.ser_cnt  = st_ff.ser_wlen;
      nxt_st.ser_div  = rfc_pkg::DIV_RST;
      nxt_st.ser_clk  = 1'b0;
      // First bit is set up a whole low phase ahead of the first rise
      nxt_st.ser_dat  = ser_load[rfc_pkg::SER_W-1];
      nxt_st.sel_a    = !st_ff.ser_wsel;
      nxt_st.sel_b    = st_ff.ser_wsel;
    end else if (st_ff.ser_act) begin
      if (st_ff.ser_div == 8'(rfc_pkg::SER_HALF_CYC - 1)) begin
        nxt_st.ser_div = rfc_pkg::DIV_RST;
        if (!st_ff.ser_clk) begin
          if (st_ff.ser_cnt == '0) begin
            nxt_st.ser_act = 1'b0;
            nxt_st.sel_a   = 1'b0;
            nxt_st.sel_b   = 1'b0;
            nxt_st.ser_dat = 1'b0;
          end else begin
            // End of a low phase: the far end samples the settled bit on this rise
            nxt_st.ser_clk = 1'b1;
            nxt_st.ser_cnt = st_ff.ser_cnt - 5'h01;
          end
        end else begin
          // Data moves only on the fall so it is stable across the next rise
          nxt_st.ser_clk = 1'b0;
          nxt_st.ser_dat = st_ff.ser_sh[rfc_pkg::SER_W-1];
          nxt_st.ser_sh  = st_ff.ser_sh << 1;
        end
      end else begin
        nxt_st.ser_div = st_ff.ser_div + 8'h01;
      end
    end
    if (ser_wr) begin
      nxt_st.ser_wbuf = ser_wr_data;
      nxt_st.ser_wlen = (ser_wr_len > 5'(rfc_pkg::SER_W)) ? 5'(rfc_pkg::SER_W) : ser_wr_len;
      nxt_st.ser_wsel = ser_wr_sel;
      nxt_st.ser_pend = (ser_wr_len != '0);
    end

    // Timed bus: shadow copy goes live only on the frame event
    if (par_wr) begin
      nxt_st.par_wbuf = par_wr_data;
    end
    if (frame_event_valid) begin
      nxt_st.par_bus = st_ff.par_wbuf;
    end

    // Profile, scale and slot tables; contents alone decide the ramp shape
    if (prof_wr && prof_bank < 3'(rfc_pkg::NBANK)) begin
      nxt_st.prof[prof_bank][prof_idx] = prof_val;
    end
    if (scl_wr && prof_bank < 3'(rfc_pkg::NBANK)) begin
      nxt_st.scl_l[prof_bank] = scl_left;
      nxt_st.scl_r[prof_bank] = scl_right;
    end
    if (slot_wr && slot_idx < 3'(rfc_pkg::NSLOT)) begin
      nxt_st.slot_bank[slot_idx] = slot_bank_sel;
      nxt_st.slot_en[slot_idx]   = slot_enable;
    end

    // Ramp engine: one sample per tick, 32 samples per event
    if (st_ff.rmp_act) begin
      if (st_ff.rmp_div == 8'(rfc_pkg::RAMP_TICK_CYC - 1)) begin
        nxt_st.rmp_div = rfc_pkg::DIV_RST;
        nxt_st.rmp_dac = smp_out;
        nxt_st.rmp_k   = st_ff.rmp_k + 5'h01;
        if (st_ff.rmp_k == 5'(rfc_pkg::NSAMP - 1)) begin
          nxt_st.rmp_act = 1'b0;
        end
      end else begin
        nxt_st.rmp_div = st_ff.rmp_div + 8'h01;
      end
    end
    // A new event cuts short a ramp still running, as back-to-back slots need
    if (frame_start) begin
      nxt_st.slot_cnt = '0;
    end else if (ramp_event && st_ff.slot_cnt < 3'(rfc_pkg::NSLOT)) begin
      nxt_st.slot_cnt = st_ff.slot_cnt + 3'h1;
      if (st_ff.slot_en[st_ff.slot_cnt]
          && st_ff.slot_bank[st_ff.slot_cnt] < 3'(rfc_pkg::NBANK)) begin
        nxt_st.rmp_act  = 1'b1;
        nxt_st.rmp_bank = st_ff.slot_bank[st_ff.slot_cnt];
        nxt_st.rmp_k    = '0;
        nxt_st.rmp_div  = rfc_pkg::DIV_RST;
      end
    end

    if (ft_wr) begin
      nxt_st.ft_code = ft_wr_code;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign serial_radio_clock         = st_ff.ser_clk;
  assign serial_radio_data          = st_ff.ser_dat;
  assign serial_radio_select_a      = st_ff.sel_a;
  assign serial_radio_select_b      = st_ff.sel_b;
  assign ser_busy                   = st_ff.ser_act;
  assign ser_pending                = st_ff.ser_pend;
  assign timed_output_bus           = st_ff.par_bus;
  assign high_band_tx_switch        = st_ff.par_bus[rfc_pkg::BIT_HIGH_BAND_TX_SWITCH];
  assign low_band_tx_switch         = st_ff.par_bus[rfc_pkg::BIT_LOW_BAND_TX_SWITCH];
  assign upper_band_rx_switch       = st_ff.par_bus[rfc_pkg::BIT_UB_RX];
  assign amplifier_enable           = st_ff.par_bus[rfc_pkg::BIT_AMP_EN];
  assign amplifier_band_select      = st_ff.par_bus[rfc_pkg::BIT_AMP_BAND];
  assign radio_module_supply_enable = st_ff.par_bus[rfc_pkg::BIT_MOD_SUP];
  assign rf_oscillator_enable       = st_ff.par_bus[rfc_pkg::BIT_OSC_EN];
  assign ramp_dac_code              = st_ff.rmp_dac;
  assign ramp_busy                  = st_ff.rmp_act;
  assign ramp_slot_count            = st_ff.slot_cnt;
  assign freq_trim_code             = st_ff.ft_code;

endmodule : rfc_radio_ctrl

// file: testbench/rfc_far_end.sv
// Behavioural transceiver end of the serial programming port
`timescale 1ns/1ps
module rfc_far_end (
  input  wire logic        serial_radio_clock,
  input  wire logic        serial_radio_data,
  input  wire logic        serial_radio_select_a,
  input  wire logic        serial_radio_select_b,
  output logic [23:0]      rx_word = 24'h0,
  output logic [4:0]       rx_bits = 5'h0,
  output logic             rx_sel_b = 1'b0
);
  // Shifts on the rising clock only inside a selected frame
  always @(posedge serial_radio_clock) begin
    if (serial_radio_select_a || serial_radio_select_b) begin
      rx_word <= {rx_word[22:0], serial_radio_data};
      rx_bits <= rx_bits + 5'h1;
      rx_sel_b <= serial_radio_select_b;
    end
  end
endmodule : rfc_far_end

// file: testbench/rfc_radio_ctrl_checker.sv
// Port checker for the radio interface control block
`timescale 1ns/1ps
module rfc_radio_ctrl_checker (
  input wire logic ref_clk, resetn, clk_en, frame_event_valid, frame_start, ft_wr,
  input wire logic [12:0] ft_wr_code, freq_trim_code,
  input wire logic serial_radio_clock, serial_radio_select_a, serial_radio_select_b,
  input wire logic ser_busy, ser_pending, ramp_busy, high_band_tx_switch,
  input wire logic low_band_tx_switch, upper_band_rx_switch, amplifier_enable,
  input wire logic amplifier_band_select, radio_module_supply_enable, rf_oscillator_enable,
  input wire logic [9:0] timed_output_bus, ramp_dac_code,
  input wire logic [2:0] ramp_slot_count
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_sel_excl; !(serial_radio_select_a && serial_radio_select_b); endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("both selects high");
  property p_start; $rose(ser_busy) |-> $past(frame_event_valid) && $past(ser_pending); endproperty
  a_start: assert property (p_start) else $error("transfer without event");
  property p_clk_frame; serial_radio_clock |-> serial_radio_select_a || serial_radio_select_b;
  endproperty
  a_clk_frame: assert property (p_clk_frame) else $error("clock outside frame");
  // Event latency is one edge; the check also lets the second history step explain a change
  property p_bus; $changed(timed_output_bus) |-> $past(frame_event_valid, 1)
    || $past(frame_event_valid, 2); endproperty
  a_bus: assert property (p_bus) else $error("bus moved without event");
  property p_named; {rf_oscillator_enable, radio_module_supply_enable, amplifier_band_select,
    amplifier_enable, upper_band_rx_switch, low_band_tx_switch, high_band_tx_switch} ==
    {timed_output_bus[9:8], timed_output_bus[5:4], timed_output_bus[2:0]}; endproperty
  a_named: assert property (p_named) else $error("named line mismatch");
  property p_ft; ft_wr && clk_en |=> freq_trim_code == $past(ft_wr_code); endproperty
  a_ft: assert property (p_ft) else $error("trim code not taken");
  property p_frame; frame_start && clk_en |=> ramp_slot_count == 3'h0; endproperty
  a_frame: assert property (p_frame) else $error("slot count not cleared");
  property p_pace; ramp_busy && $changed(ramp_dac_code) |=> $stable(ramp_dac_code) [*8];
  endproperty
  a_pace: assert property (p_pace) else $error("sample faster than tick");
endmodule : rfc_radio_ctrl_checker
bind rfc_radio_ctrl rfc_radio_ctrl_checker u_chk (.*);

// file: testbench/test_rfc_radio_ctrl.sv
// Self-checking bench for the radio interface control block
`timescale 1ns/1ps
module test_rfc_radio_ctrl;
  logic ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, frame_event_valid = 1'b0;
  logic frame_start = 1'b0, ramp_event = 1'b0, ser_wr = 1'b0, ser_wr_sel = 1'b0;
  logic par_wr = 1'b0, prof_wr = 1'b0, scl_wr = 1'b0, slot_wr = 1'b0, slot_enable = 1'b0;
  logic ft_wr = 1'b0, rx_sel_b;
  logic [23:0] ser_wr_data = 24'h0, rx_word, d;
  logic [4:0] ser_wr_len = 5'h0, rx_bits, base;
  logic [9:0] par_wr_data = 10'h0, scl_left = 10'h0, scl_right = 10'h0, w, prev, sl, sr;
  logic [2:0] prof_bank = 3'h0, slot_idx = 3'h0, slot_bank_sel = 3'h0, ramp_slot_count;
  logic [3:0] prof_idx = 4'h0;
  logic [7:0] prof_val = 8'h0, ent [16];
  logic [12:0] ft_wr_code = 13'h0, freq_trim_code;
  logic serial_radio_clock, serial_radio_data, serial_radio_select_a, serial_radio_select_b;
  logic ser_busy, ser_pending, high_band_tx_switch, low_band_tx_switch, upper_band_rx_switch;
  logic amplifier_enable, amplifier_band_select, radio_module_supply_enable;
  logic rf_oscillator_enable, ramp_busy;
  logic [9:0] timed_output_bus, ramp_dac_code;
  int err_total = 0, check_count = 0, len;
  rfc_radio_ctrl u_dut (.*);
  rfc_far_end u_far (.serial_radio_clock, .serial_radio_data, .serial_radio_select_a,
    .serial_radio_select_b, .rx_word, .rx_bits, .rx_sel_b);
  always #25 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic pulse_event;
    @(posedge ref_clk) frame_event_valid <= 1'b1;
    @(posedge ref_clk) frame_event_valid <= 1'b0;
  endtask : pulse_event
  task automatic pulse_ramp;
    @(posedge ref_clk) ramp_event <= 1'b1;
    @(posedge ref_clk) ramp_event <= 1'b0;
  endtask : pulse_ramp
  // Truncation keeps product bits 17:8
  function automatic logic [9:0] val(input int i);
    logic [17:0] p;
    p = ent[i] * ((i < 8) ? sl : sr);
    return p[17:8];
  endfunction : val
  function automatic logic [9:0] samp(input int k);
    if (k == 31 || k % 2 == 0) return val(k / 2);
    return 10'((11'(val(k / 2)) + 11'(val(k / 2 + 1))) / 2);
  endfunction : samp
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    finish_test;
  end
  initial begin
    void'($urandom(32'ha0b8c315));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    check(timed_output_bus, 0);
    prev = 10'h0;
    for (int n = 0; n < 6; n++) begin
      w = (n == 0) ? 10'h3ff : 10'($urandom);
      @(posedge ref_clk) {par_wr, par_wr_data} <= {1'b1, w};
      @(posedge ref_clk) par_wr <= 1'b0;
      repeat (3) @(negedge ref_clk);
      check(timed_output_bus, prev);
      pulse_event;
      repeat (2) @(negedge ref_clk);
      check(timed_output_bus, w);
      prev = w;
    end
    @(posedge ref_clk) {ft_wr, ft_wr_code} <= {1'b1, 13'h1fff & 13'($urandom)};
    @(posedge ref_clk) ft_wr <= 1'b0;
    @(negedge ref_clk);
    check(freq_trim_code, ft_wr_code);
    for (int n = 0; n < 2; n++) begin
      len = (n == 0) ? 24 : 1 + $urandom % 23;
      d = 24'($urandom);
      base = rx_bits;
      @(posedge ref_clk) {ser_wr, ser_wr_data, ser_wr_len, ser_wr_sel} <= {1'b1, d, 5'(len), n[0]};
      @(posedge ref_clk) ser_wr <= 1'b0;
      repeat (12) @(negedge ref_clk);
      check({ser_pending, rx_bits}, {1'b1, base});
      pulse_event;
      repeat (3) @(negedge ref_clk);
      for (int t = 0; t < 300 && ser_busy !== 1'b0; t++) @(negedge ref_clk);
      check(5'(rx_bits - base), len);
      check(rx_word & 24'((64'h1 << len) - 1), d & 24'((64'h1 << len) - 1));
      check({rx_sel_b, ser_pending}, {n[0], 1'b0});
    end
    // Bank 4 shows the highest of the five banks is reachable; entry 15 at full scale
    sl = 10'($urandom);
    sr = 10'h3ff;
    for (int i = 0; i < 16; i++) begin
      ent[i] = (i == 15) ? 8'hff : 8'($urandom);
      @(posedge ref_clk) {prof_wr, prof_bank, prof_idx, prof_val} <= {1'b1, 3'h4, 4'(i), ent[i]};
    end
    @(posedge ref_clk) {prof_wr, scl_wr, scl_left, scl_right} <= {1'b0, 1'b1, sl, sr};
    {slot_wr, slot_idx, slot_bank_sel, slot_enable} <= {1'b1, 3'h0, 3'h4, 1'b1};
    @(posedge ref_clk) {scl_wr, slot_wr, frame_start} <= 3'b001;
    @(posedge ref_clk) frame_start <= 1'b0;
    pulse_ramp;
    repeat (30) @(negedge ref_clk);
    for (int k = 0; k < 32; k++) begin
      check({ramp_busy, ramp_dac_code}, {(k < 31), samp(k)});
      repeat (20) @(negedge ref_clk);
    end
    check({ramp_busy, ramp_dac_code, ramp_slot_count}, {1'b0, val(15), 3'h1});
    @(posedge ref_clk) frame_start <= 1'b1;
    @(posedge ref_clk) frame_start <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      pulse_ramp;
      @(negedge ref_clk);
      check(ramp_slot_count, (n < 7) ? n + 1 : 7);
    end
    finish_test;
  end
endmodule : test_rfc_radio_ctrl
